// ===== hdl/lmx_dev.sv
// Purpose: controller end of the mark link
// Assumes: connector inputs arrive from pins; cnc core signals same clock
// Notes: registers over a plain strobe port
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`include "lmx_consts.svh"
module lmx_dev
   import lmx_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   lmx_if.dev net,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   output logic irq,
   input wire logic [10:0] conn_in,
   input wire logic [36:0] cnc_out,
   input wire logic [10:0] cnc_stat,
   input wire logic fn_exec,
   input wire lmx_kind_type fn_kind,
   input wire logic [15:0] fn_code,
   input wire logic block_end,
   input wire logic next_mst_only,
   input wire logic delete_key,
   output logic feed_hold,
   output logic xfer_inhibit,
   output logic fn_done,
   output logic exec_halt,
   output logic [15:0] msg_shown,
   output logic msg_valid
);
   logic [10:0] s1_q, s2_q, s3_q, conn_q;
   logic [3:0] ctrl_q;
   logic [3:0] node_q;
   logic [15:0] base_q;
   logic [3:0] send_group_q;
   logic [2:0] stat_q, mask_q;
   logic net_inh_q, net_done_q;
   logic halt_q;
   logic [15:0] last_msg_q;
   logic code_valid_q;
   logic [3:0] code_node_q;
   logic [15:0] code_reg_q, code_value_q;
   logic [511:0] marks_q;
   logic sel_found;
   logic [15:0] sel_num;
   logic inh_low, ev_code, ev_msg, ev_inh;
   logic inhibit_src, spares;

   // pins pass three flops; set needs second and third both high, clears when they differ
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s1_q <= 11'h000;
         s2_q <= 11'h000;
         s3_q <= 11'h000;
         conn_q <= 11'h000;
      end else begin
         s1_q <= conn_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         conn_q <= (s2_q & s3_q) | (conn_q & ~(s2_q ^ s3_q));
      end
   end

   assign inhibit_src = ctrl_q[`LMX_CTRL_SRC];
   assign spares = ctrl_q[`LMX_CTRL_SPARE] & inhibit_src;

   // register writes
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrl_q <= 4'h0;
         node_q <= 4'h0;
         base_q <= 16'h0000;
         send_group_q <= 4'h0;
         mask_q <= 3'h0;
      end else if (reg_wr) begin
         case (reg_addr)
            `LMX_REG_CTRL: ctrl_q <= reg_wdata[3:0];
            `LMX_REG_DEST: node_q <= reg_wdata[3:0];
            `LMX_REG_MASK: mask_q <= reg_wdata[2:0];
            `LMX_REG_LINK: send_group_q <= reg_wdata[3:0];
            `LMX_REG_TX: base_q <= reg_wdata;
            default: ;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `LMX_REG_CTRL: reg_rdata <= {12'h000, ctrl_q};
            `LMX_REG_DEST: reg_rdata <= {12'h000, node_q};
            `LMX_REG_STAT: reg_rdata <= {13'h0000, stat_q};
            `LMX_REG_MASK: reg_rdata <= {13'h0000, mask_q};
            `LMX_REG_MSG: reg_rdata <= msg_shown;
            `LMX_REG_LINK: reg_rdata <= {12'h000, send_group_q};
            `LMX_REG_TX: reg_rdata <= base_q;
            default: reg_rdata <= 16'h0000;
         endcase
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

   // network inhibit and done latched until the next strobe
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         net_inh_q <= 1'b1;
         net_done_q <= 1'b0;
      end else if (net.net_in_strobe) begin
         net_inh_q <= net.net_in_reg[`LMX_INH_BIT];
         net_done_q <= net.net_in_reg[`LMX_DONE_BIT];
      end
   end

   assign feed_hold = conn_q[2];
   // one shared pin when select clear
   assign xfer_inhibit = inhibit_src ? net_inh_q : conn_q[2];
   assign fn_done = inhibit_src ? net_done_q : conn_q[2];
   assign inh_low = ~xfer_inhibit;

   // hold policy applied at block end
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         halt_q <= 1'b0;
      end else if (!inh_low) begin
         halt_q <= 1'b0;
      end else if (block_end) begin
         if (!spares) begin
            halt_q <= 1'b1;
         end else begin
            halt_q <= ~next_mst_only;
         end
      end
   end
   assign exec_halt = halt_q;

   // function code sender
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         code_valid_q <= 1'b0;
         code_node_q <= 4'h0;
         code_reg_q <= 16'h0000;
         code_value_q <= 16'h0000;
      end else begin
         code_valid_q <= fn_exec & ctrl_q[`LMX_CTRL_PRES];
         // fields move only with a send, so a receiver never sees them drift
         if (fn_exec && ctrl_q[`LMX_CTRL_PRES]) begin
            code_node_q <= node_q;
            code_value_q <= fn_code;
            code_reg_q <= base_q + {14'h0000, fn_kind};
         end
      end
   end
   assign ev_code = code_valid_q;
   assign net.code_valid = code_valid_q;
   assign net.code_node = code_node_q; // 15 is broadcast at receiver
   assign net.code_reg = code_reg_q;
   assign net.code_value = code_value_q;

   lmx_msg_sel #(.N(99)) u_sel (
      .act(net.msg_marks),
      .found(sel_found),
      .num(sel_num)
   );

   // messages
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         last_msg_q <= 16'h0000;
      end else if (ctrl_q[`LMX_CTRL_MSGM]) begin
         last_msg_q <= 16'h0000;
      end else if (net.msg_strobe) begin
         last_msg_q <= net.msg_num;
      end else if (net.msg_instr) begin
         last_msg_q <= net.msg_num;
      end else if (delete_key) begin
         last_msg_q <= 16'h0000;
      end
   end
   assign msg_shown = ctrl_q[`LMX_CTRL_MSGM] ? sel_num
                                             : last_msg_q;
   assign msg_valid = ctrl_q[`LMX_CTRL_MSGM] ? sel_found
                                             : (last_msg_q != 16'h0000);
   assign ev_msg = ctrl_q[`LMX_CTRL_MSGM] ? 1'b0
                                          : (net.msg_strobe | net.msg_instr);
   assign ev_inh = inh_low & block_end;

   // sticky status, set wins over write-one clear
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         stat_q <= 3'h0;
      end else begin
         stat_q <= (stat_q & ~((reg_wr && reg_addr == `LMX_REG_STAT)
                   ? reg_wdata[2:0] : 3'h0)) | {ev_inh, ev_msg, ev_code};
      end
   end
   assign irq = |(stat_q & mask_q);

   // shared mark groups; group 0 sends nothing and no update group used
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         marks_q <= 512'h0;
      end else begin
         marks_q <= 512'h0;
         for (int g = 1; g <= `LMX_GROUPS; g++) begin
            if (send_group_q == 4'(g)) begin
               marks_q[64*(g-1) + `LMX_IN_OFS - 1 +: 11] <= conn_q;
               marks_q[64*(g-1) + `LMX_OUT_OFS - 1 +: 37]
                  <= cnc_out;
               marks_q[64*(g-1) + `LMX_STAT_OFS - 1 +: 11]
                  <= cnc_stat;
            end
         end
      end
   end
   assign net.marks = marks_q;
endmodule // lmx_dev

// ===== hdl/lmx_consts.svh
// Purpose: offsets, field positions, register addresses and counts of the mark link
// Assumes: included by bare name
// Notes: definitions only
`ifndef LMX_CONSTS_SVH
`define LMX_CONSTS_SVH
`define LMX_GROUPS 8
`define LMX_GROUP_MARKS 64
`define LMX_BCAST_NODE 4'hf
`define LMX_INH_BIT 0
`define LMX_DONE_BIT 1
`define LMX_IN_OFS 1
`define LMX_OUT_OFS 12
`define LMX_STAT_OFS 49
`define LMX_MSG_FIRST 16'd1801
`define LMX_MSG_LAST 16'd1899
`define LMX_REG_CTRL 4'h0
`define LMX_REG_DEST 4'h1
`define LMX_REG_STAT 4'h2
`define LMX_REG_MASK 4'h3
`define LMX_REG_MSG 4'h4
`define LMX_REG_LINK 4'h5
`define LMX_REG_TX 4'h6
`define LMX_CTRL_SRC 0
`define LMX_CTRL_SPARE 1
`define LMX_CTRL_PRES 2
`define LMX_CTRL_MSGM 3
`define LMX_ST_CODE 0
`define LMX_ST_MSG 1
`define LMX_ST_INH 2
`endif

// ===== hdl/lmx_pkg.sv
// Purpose: shared types of the mark link
// Assumes: nothing
// Notes: constants live in lmx_consts.svh
package lmx_pkg;
   typedef enum logic [1:0] {
      lmx_kind_m_type = 2'h0,
      lmx_kind_s_type = 2'h1,
      lmx_kind_t_type = 2'h2
   } lmx_kind_type;
endpackage

// ===== hdl/lmx_if.sv
// Purpose: network side joining the controller end and the logic controller
// Assumes: one clock
// Notes: word writes are one-cycle strobes
`timescale 1ns/1ps
interface lmx_if;
   logic [511:0] marks;
   logic [15:0] net_in_reg;
   logic net_in_strobe;
   logic [15:0] msg_num;
   logic msg_strobe;
   logic msg_instr;
   logic [98:0] msg_marks;
   logic code_valid;
   logic [3:0] code_node;
   logic [15:0] code_reg;
   logic [15:0] code_value;
   modport dev (output marks, output code_valid, output code_node,
      output code_reg, output code_value, input net_in_reg,
      input net_in_strobe, input msg_num, input msg_strobe,
      input msg_instr, input msg_marks);
   modport plc (input marks, input code_valid, input code_node,
      input code_reg, input code_value, output net_in_reg,
      output net_in_strobe, output msg_num, output msg_strobe,
      output msg_instr, output msg_marks);
endinterface

// ===== hdl/lmx_msg_sel.sv
// Purpose: pick the highest priority active message mark
// Assumes: lower mark number means higher priority
// Notes: combinational priority encoder
`timescale 1ns/1ps
`include "lmx_consts.svh"
module lmx_msg_sel #(
   parameter int N = 99
) (
   input wire logic [N-1:0] act,
   output logic found,
   output logic [15:0] num
);
   always_comb begin
      found = 1'b0;
      num = 16'h0000;
      for (int i = N - 1; i >= 0; i--) begin
         if (act[i]) begin
            found = 1'b1;
            num = `LMX_MSG_FIRST + 16'(i);
         end
      end
   end
endmodule // lmx_msg_sel

// ===== hdl/lmx_plc.sv
// Purpose: logic controller end of the mark link
// Assumes: user port drives requests for one cycle
// Notes: stores received codes in a small register array
`timescale 1ns/1ps
`include "lmx_consts.svh"
module lmx_plc
   import lmx_pkg::*;
#(
   parameter logic [3:0] MY_NODE = 4'h1,
   parameter int REGS = 256
) (
   input wire logic ref_clk,
   input wire logic rst,
   lmx_if.plc net,
   input wire logic set_net_in,
   input wire logic inhibit_high,
   input wire logic done_high,
   input wire logic send_msg,
   input wire logic use_instr,
   input wire logic [15:0] msg_number,
   input wire logic [98:0] msg_mark_bits,
   input wire logic [7:0] rd_index,
   output logic [15:0] rd_value,
   output logic [511:0] marks_seen
);
   logic [15:0] regs_q [REGS];
   logic [15:0] net_reg_q, msg_num_q;
   logic net_stb_q, msg_stb_q, msg_instr_q;
   logic [98:0] msg_marks_q;

   // inhibit bit 0, done bit 1, with input strobe
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         net_reg_q <= 16'h0001;
         net_stb_q <= 1'b0;
      end else begin
         net_stb_q <= set_net_in;
         if (set_net_in) begin
            net_reg_q <= {14'h0000, done_high, inhibit_high};
         end
      end
   end

   // message marks preferred; strobe path kept for older programs
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         msg_num_q <= 16'h0000;
         msg_stb_q <= 1'b0;
         msg_instr_q <= 1'b0;
         msg_marks_q <= 99'h0;
      end else begin
         msg_marks_q <= msg_mark_bits;
         msg_stb_q <= send_msg & ~use_instr;
         msg_instr_q <= send_msg & use_instr;
         if (send_msg) begin
            msg_num_q <= msg_number;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         for (int i = 0; i < REGS; i++) begin
            regs_q[i] <= 16'h0000;
         end
      end else if (net.code_valid && (net.code_node == MY_NODE
               || net.code_node == `LMX_BCAST_NODE)) begin
         regs_q[net.code_reg[7:0]] <= net.code_value;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rd_value <= 16'h0000;
         marks_seen <= 512'h0;
      end else begin
         rd_value <= regs_q[rd_index];
         marks_seen <= net.marks;
      end
   end

   assign net.net_in_reg = net_reg_q;
   assign net.net_in_strobe = net_stb_q;
   assign net.msg_num = msg_num_q;
   assign net.msg_strobe = msg_stb_q;
   assign net.msg_instr = msg_instr_q;
   assign net.msg_marks = msg_marks_q;
endmodule // lmx_plc

// ===== tb/lmx_chk_sva.sv
// Purpose: wire checks on the mark link between both ends
// Assumes: one clock, synchronous active high reset
// Notes: sees interface signals only
`timescale 1ns/1ps
module lmx_chk (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [511:0] marks,
   input wire logic [15:0] net_in_reg,
   input wire logic net_in_strobe,
   input wire logic msg_strobe,
   input wire logic msg_instr,
   input wire logic code_valid,
   input wire logic [3:0] code_node,
   input wire logic [15:0] code_reg,
   input wire logic [15:0] code_value
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   logic [7:0] grp_on;
   logic tail_on;
   // offsets 60..64 of every group carry nothing
   always_comb begin
      tail_on = 1'h0;
      for (int g = 0; g < 8; g++) begin
         grp_on[g] = |marks[64*g +: 64];
         tail_on = tail_on | (|marks[64*g+59 +: 5]);
      end
   end
   sequence s_quiet;
      (marks == 512'h0) [*3];
   endsequence
   property p_boot_quiet;
      $fell(rst) |-> s_quiet;
   endproperty
   property p_one_group;
      $onehot0(grp_on);
   endproperty
   property p_tail_zero;
      !tail_on;
   endproperty
   property p_code_hold;
      !code_valid |-> $stable({code_node, code_reg, code_value});
   endproperty
   property p_msg_excl;
      !(msg_strobe && msg_instr);
   endproperty
   // only inhibit and done may be carried with the input strobe
   property p_in_clean;
      net_in_strobe |-> (net_in_reg[15:2] == 14'h0000);
   endproperty
   a_boot_quiet: assert property (p_boot_quiet)
      else $error("marks not clear after reset");
   a_one_group: assert property (p_one_group)
      else $error("marks in more than one group");
   a_tail_zero: assert property (p_tail_zero)
      else $error("mark beyond offset 59 set");
   a_code_hold: assert property (p_code_hold)
      else $error("code fields moved without valid");
   a_msg_excl: assert property (p_msg_excl)
      else $error("message strobe and instruction together");
   a_in_clean: assert property (p_in_clean)
      else $error("network input word has stray bits with strobe");
endmodule // lmx_chk

// ===== tb/tb_lan_mark_exchange_control.sv
// Purpose: drives both ends of the mark link through their user ports
// Assumes: default plc node 1
// Notes: expectations derived from offsets and register layout
`timescale 1ns/1ps
`include "lmx_consts.svh"
module tb_lan_mark_exchange_control;
   logic ref_clk = 1'h0;
   logic rst = 1'h1;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0, reg_rdata, fn_code = 16'h0;
   logic [15:0] msg_number = 16'h0, msg_shown, rd_value;
   logic reg_wr = 1'h0, reg_rd = 1'h0, fn_exec = 1'h0, block_end = 1'h0;
   logic next_mst_only = 1'h0, delete_key = 1'h0, set_net_in = 1'h0;
   logic inhibit_high = 1'h0, done_high = 1'h0, send_msg = 1'h0;
   logic use_instr = 1'h0, irq, feed_hold, xfer_inhibit, fn_done;
   logic exec_halt, msg_valid;
   logic [10:0] conn_in = 11'h0, cnc_stat = 11'h0;
   logic [36:0] cnc_out = 37'h0;
   lmx_pkg::lmx_kind_type fn_kind = lmx_pkg::lmx_kind_m_type;
   logic [98:0] msg_mark_bits = 99'h0;
   logic [7:0] rd_index = 8'h0;
   logic [511:0] marks_seen, pat, exp_marks;
   int n_errors = 0, n_tests = 0;
   lmx_if net ();
   lmx_dev lmx_dev_inst (.ref_clk(ref_clk), .rst(rst), .net(net),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .conn_in(conn_in),
      .cnc_out(cnc_out), .cnc_stat(cnc_stat), .fn_exec(fn_exec),
      .fn_kind(fn_kind), .fn_code(fn_code), .block_end(block_end),
      .next_mst_only(next_mst_only), .delete_key(delete_key),
      .feed_hold(feed_hold), .xfer_inhibit(xfer_inhibit), .fn_done(fn_done),
      .exec_halt(exec_halt), .msg_shown(msg_shown), .msg_valid(msg_valid));
   lmx_plc lmx_plc_inst (.ref_clk(ref_clk), .rst(rst), .net(net),
      .set_net_in(set_net_in), .inhibit_high(inhibit_high),
      .done_high(done_high), .send_msg(send_msg), .use_instr(use_instr),
      .msg_number(msg_number), .msg_mark_bits(msg_mark_bits),
      .rd_index(rd_index), .rd_value(rd_value), .marks_seen(marks_seen));
   lmx_chk lmx_chk_inst (.ref_clk(ref_clk), .rst(rst), .marks(net.marks),
      .net_in_reg(net.net_in_reg), .net_in_strobe(net.net_in_strobe),
      .msg_strobe(net.msg_strobe), .msg_instr(net.msg_instr),
      .code_valid(net.code_valid), .code_node(net.code_node),
      .code_reg(net.code_reg), .code_value(net.code_value));
   always #25 ref_clk = ~ref_clk;
   task automatic chk(string s, logic [511:0] e, logic [511:0] g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %0h seen %0h", s, e, g);
      end
   endtask
   // lands past the edge so registered outputs have settled
   task automatic wt(int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic wr(logic [3:0] a, logic [15:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge ref_clk);
      reg_wr <= 1'h0;
   endtask
   task automatic rd(logic [3:0] a, logic [15:0] e, string s);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge ref_clk);
      reg_rd <= 1'h0;
      #1;
      chk(s, e, reg_rdata);
   endtask
   task automatic pin(logic v);
      @(posedge ref_clk);
      conn_in[2] <= v;
      wt(6);
   endtask
   task automatic netw(logic i, logic d);
      @(posedge ref_clk);
      set_net_in <= 1'h1;
      inhibit_high <= i;
      done_high <= d;
      @(posedge ref_clk);
      set_net_in <= 1'h0;
      wt(3);
   endtask
   task automatic blk(logic n);
      @(posedge ref_clk);
      block_end <= 1'h1;
      next_mst_only <= n;
      @(posedge ref_clk);
      block_end <= 1'h0;
      wt(2);
   endtask
   task automatic send(logic [1:0] k, logic [15:0] c);
      @(posedge ref_clk);
      fn_exec <= 1'h1;
      fn_kind <= lmx_pkg::lmx_kind_type'(k);
      fn_code <= c;
      @(posedge ref_clk);
      fn_exec <= 1'h0;
      wt(3);
   endtask
   task automatic plc(logic [7:0] i, logic [15:0] e);
      @(posedge ref_clk);
      rd_index <= i;
      wt(2);
      chk("plc reg", e, rd_value);
   endtask
   task automatic msg(logic u, logic [15:0] n);
      @(posedge ref_clk);
      send_msg <= 1'h1;
      use_instr <= u;
      msg_number <= n;
      @(posedge ref_clk);
      send_msg <= 1'h0;
      wt(3);
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #1000000;
      n_errors++;
      final_report();
   end
   initial begin
      repeat (8) @(posedge ref_clk);
      rst <= 1'h0;
      rd(`LMX_REG_CTRL, 16'h0, "ctrl");
      rd(4'hf, 16'h0, "unmapped");
      pin(1'h1);
      chk("feed", 1'h1, feed_hold);
      chk("inh", 1'h1, xfer_inhibit);
      chk("done", 1'h1, fn_done);
      pin(1'h0);
      wr(`LMX_REG_CTRL, 16'h2);
      blk(1'h1);
      chk("halt", 1'h1, exec_halt);
      pin(1'h1);
      chk("resume", 1'h0, exec_halt);
      $display("test pins done");
      wr(`LMX_REG_CTRL, 16'h1);
      netw(1'h0, 1'h1);
      chk("net inh", 1'h0, xfer_inhibit);
      chk("net done", 1'h1, fn_done);
      pin(1'h0);
      chk("pin feed", 1'h0, feed_hold);
      chk("held", 1'h0, xfer_inhibit);
      wr(`LMX_REG_MASK, 16'h4);
      blk(1'h1);
      chk("halt", 1'h1, exec_halt);
      chk("irq", 1'h1, irq);
      rd(`LMX_REG_STAT, 16'h4, "stat");
      wr(`LMX_REG_STAT, 16'h4);
      wt(1);
      chk("irq clr", 1'h0, irq);
      netw(1'h1, 1'h0);
      chk("run", 1'h0, exec_halt);
      wr(`LMX_REG_CTRL, 16'h3);
      netw(1'h0, 1'h0);
      blk(1'h1);
      chk("mst", 1'h0, exec_halt);
      blk(1'h0);
      chk("motion", 1'h1, exec_halt);
      netw(1'h1, 1'h0);
      $display("test network inhibit done");
      wr(`LMX_REG_STAT, 16'h7);
      wr(`LMX_REG_MASK, 16'h1);
      wr(`LMX_REG_CTRL, 16'h4);
      wr(`LMX_REG_DEST, 16'h1);
      wr(`LMX_REG_TX, 16'h14);
      for (int k = 0; k < 3; k++)
         send(2'(k), 16'h100 + 16'(k));
      for (int k = 0; k < 3; k++)
         plc(8'h14 + 8'(k), 16'h100 + 16'(k));
      chk("irq code", 1'h1, irq);
      wr(`LMX_REG_DEST, 16'hf);
      send(2'h0, 16'h55);
      plc(8'h14, 16'h55);
      wr(`LMX_REG_DEST, 16'h3);
      send(2'h0, 16'h66);
      plc(8'h14, 16'h55);
      wr(`LMX_REG_CTRL, 16'h0);
      wr(`LMX_REG_DEST, 16'h1);
      send(2'h1, 16'h77);
      plc(8'h15, 16'h101);
      $display("test codes done");
      msg(1'h0, 16'h2a);
      chk("msg", 16'h2a, msg_shown);
      chk("msg valid", 1'h1, msg_valid);
      rd(`LMX_REG_MSG, 16'h2a, "msg reg");
      @(posedge ref_clk);
      delete_key <= 1'h1;
      @(posedge ref_clk);
      delete_key <= 1'h0;
      wt(2);
      chk("deleted", 16'h0, msg_shown);
      msg(1'h1, 16'h7);
      chk("instr", 16'h7, msg_shown);
      wr(`LMX_REG_CTRL, 16'h8);
      msg_mark_bits <= 99'h88;
      msg(1'h0, 16'h9);
      chk("mark msg", `LMX_MSG_FIRST + 16'h3, msg_shown);
      $display("test messages done");
      @(posedge ref_clk);
      conn_in <= 11'h5a5;
      cnc_out <= 37'h1_2345_6789;
      cnc_stat <= 11'h3c3;
      pat = {453'h0, 11'h3c3, 37'h1_2345_6789, 11'h5a5};
      // group 9 lies past the last group and must send nothing
      for (int g = 1; g < 10; g++) begin
         wr(`LMX_REG_LINK, 16'(g));
         wt(6);
         exp_marks = g > 8 ? 512'h0 : pat << (64 * (g - 1));
         chk("marks", exp_marks, net.marks);
         chk("seen", exp_marks, marks_seen);
      end
      wr(`LMX_REG_LINK, 16'h0);
      wt(4);
      chk("group 0", 512'h0, net.marks);
      $display("test marks done");
      final_report();
   end
endmodule // tb_lan_mark_exchange_control
